// >>> rpp_regs.svh
// Constants for the real power pulse datapath
`ifndef RPP_REGS_SVH
`define RPP_REGS_SVH
`define RPP_SAMPLE_HZ     900000
`define RPP_CLK_HZ        25000000
`define RPP_SAMPLE_DIV    (`RPP_CLK_HZ / `RPP_SAMPLE_HZ)
`define RPP_BW_HZ         14000
`define RPP_HPF_SHIFT     10
`define RPP_LPF_SHIFT     8
`define RPP_SLOW_THRESH   48'h0000_4000_0000
`define RPP_CAL_THRESH_HI 48'h0000_0010_0000
`define RPP_CAL_THRESH_LO 48'h0000_0080_0000
`define RPP_PULSE_LEN     16'h0100
`define RPP_GAIN_X1       2'h0
`define RPP_GAIN_X2       2'h1
`define RPP_GAIN_X8       2'h2
`define RPP_GAIN_X16      2'h3
`define RPP_SH_X1         5'h00
`define RPP_SH_X2         5'h01
`define RPP_SH_X8         5'h03
`define RPP_SH_X16        5'h04
`endif

// >>> rpp_pkg.sv
// Types for the real power pulse datapath
package rpp_pkg;
    typedef enum logic [1:0]
    {
        RPP_PHASE_A = 2'b01,
        RPP_PHASE_B = 2'b10
    } rpp_phase_t;
endpackage

// >>> rpp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rpp_fifo
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             do_wr;
    logic             do_rd;

    // Read data is registered; out_valid tracks a non-empty store
    always_comb
    begin
        do_wr = in_valid_i && (count != DEPTH[AW:0]);
        do_rd = out_ready_i && (count != '0);
        next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready_o <= (next_count != DEPTH[AW:0]);
            out_valid_o <= (next_count != '0);
            out_data_o <= (do_wr && (next_count == 1)) ? in_data_i : mem[next_rd_ptr];
        end
    end

    // Storage has no reset; pointers, count and output registers carry the reset state
    always_ff @(posedge clk_i)
    begin
        if (do_wr)
            mem[wr_ptr] <= in_data_i;
    end
endmodule

// >>> rpp_datapath.sv
// Real power datapath: dc removal, multiply, low-pass and pulse outputs
// Summary of operation
// - Two 16-bit sample streams from the modulators arrive at a 900 kHz rate into the path.
// - Current samples pass a high-pass filter that removes their dc before multiplying.
// - Instantaneous power is the product of filtered current and voltage each sample.
// - A low-pass filter on the product extracts real power, the dc term.
// - Slow pulses come from accumulating real power over long intervals.
// - The calibration pulse uses a far smaller threshold so it runs much faster.
// - Both slow outputs are registered logic levels, antiphase for a stepper motor.
// - The sample rate keeps the input bandwidth at 14 kHz or more.
// - Two gain selects choose current gain 1, 2, 8 or 16.
// - The calibration rate select picks the scaling of the calibration threshold.
// - The negative power flag follows power sign, updated only on calibration pulses.
// - Reset clears every accumulator and filter register; slow output A resets high in phase A.
`timescale 1ns/1ps
`include "rpp_regs.svh"
module rpp_datapath
    import rpp_pkg::*;
#(
    parameter int SW     = 16,
    parameter int FDEPTH = 8
)
(
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic [SW-1:0] cur_sample_i,
    input  wire logic [SW-1:0] volt_sample_i,
    input  wire logic          sample_valid_i,
    output logic               sample_ready_o,
    input  wire logic          gain_select_hi_i,
    input  wire logic          gain_select_lo_i,
    input  wire logic          calib_rate_select_i,
    output logic               slow_pulse_out_a_o,
    output logic               slow_pulse_out_b_o,
    output logic               calib_pulse_out_o,
    output logic               negative_power_flag_o
);
    localparam int PW = 2 * SW + 8;
    localparam int AW = 48;

    // Sample pair buffered so the datapath consumes at its own 27-clock sample tick pace
    logic [2*SW-1:0] f_data;
    logic            f_valid;
    logic            f_ready;
    logic            take;

    rpp_fifo #(.WIDTH(2 * SW), .DEPTH(FDEPTH)) u_fifo
    (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   ({cur_sample_i, volt_sample_i}),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (sample_ready_o),
        .out_data_o  (f_data),
        .out_valid_o (f_valid),
        .out_ready_i (f_ready)
    );

    // Sample tick paces consumption once every 27 clocks, about 926 kHz
    logic [7:0] tick_cnt;
    logic [7:0] next_tick_cnt;
    logic       tick;
    always_comb
    begin
        tick = (tick_cnt == 8'(`RPP_SAMPLE_DIV - 1));
        next_tick_cnt = tick ? 8'h00 : tick_cnt + 8'h01;
        f_ready = tick;
        take = tick && f_valid;
    end
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            tick_cnt <= 8'h00;
        else
            tick_cnt <= next_tick_cnt;
    end

    // Gain decode is a pure shift; gains are powers of two
    function automatic logic [4:0] gain_shift(input logic [1:0] sel);
        case (sel)
            `RPP_GAIN_X1:  gain_shift = `RPP_SH_X1;
            `RPP_GAIN_X2:  gain_shift = `RPP_SH_X2;
            `RPP_GAIN_X8:  gain_shift = `RPP_SH_X8;
            `RPP_GAIN_X16: gain_shift = `RPP_SH_X16;
            default:       gain_shift = `RPP_SH_X1;
        endcase
    endfunction

    // Filter and multiply state
    logic signed [SW+15:0] hpf_avg;
    logic signed [SW+15:0] next_hpf_avg;
    logic signed [SW+4:0]  cur_g;
    logic signed [SW+4:0]  cur_hp;
    logic signed [SW+4:0]  next_cur_hp;
    logic signed [SW-1:0]  volt_d;
    logic signed [SW-1:0]  next_volt_d;
    logic                  hp_vld;
    logic                  next_hp_vld;
    logic signed [PW-1:0]  prod;
    logic signed [PW-1:0]  next_prod;
    logic                  prod_vld;
    logic                  next_prod_vld;
    logic signed [PW+7:0]  lpf;
    logic signed [PW+7:0]  next_lpf;
    logic                  pwr_vld;
    logic                  next_pwr_vld;
    logic signed [PW-1:0]  power;

    always_comb
    begin
        // Gain applied before dc removal so the offset estimate scales with it
        cur_g = (SW + 5)'(signed'(f_data[2*SW-1:SW])) <<< gain_shift({gain_select_hi_i,
                                                                  gain_select_lo_i});
        next_hpf_avg = hpf_avg;
        next_cur_hp = cur_hp;
        next_volt_d = volt_d;
        next_hp_vld = take;
        if (take)
        begin
            // Leaky average tracks dc; subtracting it is a first-order high-pass
            next_cur_hp = (SW + 5)'(cur_g - (SW + 5)'(hpf_avg >>> `RPP_HPF_SHIFT));
            next_hpf_avg = hpf_avg + (SW + 16)'(cur_g) - (SW + 16)'(hpf_avg >>> `RPP_HPF_SHIFT);
            next_volt_d = signed'(f_data[SW-1:0]);
        end
        next_prod_vld = hp_vld;
        next_prod = hp_vld ? PW'(cur_hp * volt_d) : prod;
        next_pwr_vld = prod_vld;
        next_lpf = lpf;
        if (prod_vld)
            next_lpf = lpf + (PW + 8)'(prod) - (lpf >>> `RPP_LPF_SHIFT);
        power = PW'(lpf >>> `RPP_LPF_SHIFT);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            hpf_avg <= '0;
            cur_hp <= '0;
            volt_d <= '0;
            hp_vld <= 1'b0;
            prod <= '0;
            prod_vld <= 1'b0;
            lpf <= '0;
            pwr_vld <= 1'b0;
        end
        else
        begin
            hpf_avg <= next_hpf_avg;
            cur_hp <= next_cur_hp;
            volt_d <= next_volt_d;
            hp_vld <= next_hp_vld;
            prod <= next_prod;
            prod_vld <= next_prod_vld;
            lpf <= next_lpf;
            pwr_vld <= next_pwr_vld;
        end
    end

    // Energy accumulation; magnitude is integrated, sign goes to the flag
    logic [AW-1:0]    mag;
    logic [AW-1:0]    slow_acc;
    logic [AW-1:0]    next_slow_acc;
    logic [AW-1:0]    cal_acc;
    logic [AW-1:0]    next_cal_acc;
    logic [AW-1:0]    cal_thr;
    logic             slow_hit;
    logic             cal_hit;
    logic             neg;
    logic             next_neg;
    logic             cal_out;
    logic             next_cal_out;
    logic [15:0]      cal_len;
    logic [15:0]      next_cal_len;
    rpp_phase_t       phase;
    rpp_phase_t       next_phase;
    logic             slow_a;
    logic             next_slow_a;
    logic             slow_b;
    logic             next_slow_b;

    always_comb
    begin
        mag = AW'(power[PW-1] ? -power : power);
        cal_thr = calib_rate_select_i ? `RPP_CAL_THRESH_HI : `RPP_CAL_THRESH_LO;
        next_slow_acc = slow_acc;
        next_cal_acc = cal_acc;
        slow_hit = 1'b0;
        cal_hit = 1'b0;
        if (pwr_vld)
        begin
            next_slow_acc = slow_acc + mag;
            next_cal_acc = cal_acc + mag;
            if (next_slow_acc >= `RPP_SLOW_THRESH)
            begin
                slow_hit = 1'b1;
                next_slow_acc = next_slow_acc - `RPP_SLOW_THRESH;
            end
            if (next_cal_acc >= cal_thr)
            begin
                cal_hit = 1'b1;
                next_cal_acc = next_cal_acc - cal_thr;
            end
        end
        next_neg = cal_hit ? power[PW-1] : neg;
        next_cal_len = cal_len;
        next_cal_out = cal_out;
        if (cal_hit)
        begin
            next_cal_out = 1'b1;
            next_cal_len = `RPP_PULSE_LEN;
        end
        else if (cal_len != 16'h0000)
            next_cal_len = cal_len - 16'h0001;
        else
            next_cal_out = 1'b0;
        // Each slow pulse steps the two-phase pattern; outputs never overlap high
        next_phase = phase;
        if (slow_hit)
        begin
            case (phase)
                RPP_PHASE_A: next_phase = RPP_PHASE_B;
                RPP_PHASE_B: next_phase = RPP_PHASE_A;
                default:     next_phase = RPP_PHASE_A;
            endcase
        end
        next_slow_a = (next_phase == RPP_PHASE_A);
        next_slow_b = (next_phase == RPP_PHASE_B);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            slow_acc <= '0;
            cal_acc <= '0;
            neg <= 1'b0;
            cal_out <= 1'b0;
            cal_len <= 16'h0000;
            phase <= RPP_PHASE_A;
            slow_a <= 1'b1;
            slow_b <= 1'b0;
        end
        else
        begin
            slow_acc <= next_slow_acc;
            cal_acc <= next_cal_acc;
            neg <= next_neg;
            cal_out <= next_cal_out;
            cal_len <= next_cal_len;
            phase <= next_phase;
            slow_a <= next_slow_a;
            slow_b <= next_slow_b;
        end
    end

    // Registered outputs
    always_comb
    begin
        slow_pulse_out_a_o = slow_a;
        slow_pulse_out_b_o = slow_b;
        calib_pulse_out_o = cal_out;
        negative_power_flag_o = neg;
    end

    // Checks
    sample_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tick |-> ##1 !tick [*8]) else $error("Sample tick too frequent");
    bw_ok_a: assert property (@(posedge clk_i) disable iff (rst_i)
        `RPP_SAMPLE_HZ >= 2 * `RPP_BW_HZ) else $error("Bandwidth short");
    prod_mul_a: assert property (@(posedge clk_i) disable iff (rst_i)
        hp_vld |=> prod == PW'($past(cur_hp) * $past(volt_d))) else $error("Bad product");
    hpf_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !take |=> $stable(hpf_avg)) else $error("Filter moved idle");
    lpf_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !prod_vld |=> $stable(lpf)) else $error("Low-pass moved idle");
    slow_acc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        slow_acc < `RPP_SLOW_THRESH) else $error("Slow accumulator over");
    cal_acc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pwr_vld && !cal_hit |=> cal_acc == $past(cal_acc) + $past(mag))
        else $error("Cal accumulate wrong");
    slow_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        slow_hit |=> slow_a != $past(slow_a) && slow_b != $past(slow_b))
        else $error("Slow output did not step");
    antiphase_a: assert property (@(posedge clk_i) disable iff (rst_i)
        slow_a != slow_b) else $error("Slow outputs overlap");
    flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !cal_hit |=> $stable(neg)) else $error("Flag changed off pulse");
    flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cal_hit |=> neg == $past(power[PW-1]) && cal_out) else $error("Flag not sampled");
    cal_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        calib_rate_select_i |-> cal_thr == `RPP_CAL_THRESH_HI) else $error("Cal scale");
    gain_a: assert property (@(posedge clk_i) disable iff (rst_i)
        {gain_select_hi_i, gain_select_lo_i} == `RPP_GAIN_X16
        |-> gain_shift({gain_select_hi_i, gain_select_lo_i}) == `RPP_SH_X16)
        else $error("Gain decode");
    reset_a: assert property (@(posedge clk_i) $fell(rst_i) |-> slow_acc == '0 && lpf == '0)
        else $error("Reset did not clear");
endmodule

// >>> rpp_pulse_partner.sv
// Pulse counter model at the meter's slow and calibration outputs
`timescale 1ns/1ps
module rpp_pulse_partner
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        slow_a_i,
    input  wire logic        slow_b_i,
    input  wire logic        cal_i,
    input  wire logic        flag_i,
    output logic      [15:0] steps_o,
    output logic      [15:0] cal_edges_o,
    output logic      [15:0] cal_width_o,
    output logic             flag_at_cal_o,
    output logic      [15:0] err_o
);
    logic        prev_a;
    logic        prev_cal;
    logic        prev_flag;
    logic [15:0] width;
    logic        bad_phase;
    logic        bad_flag;

    // A stepper needs both phases opposite; the flag may only move with a cal pulse
    assign bad_phase = (slow_a_i == slow_b_i);
    assign bad_flag  = (flag_i != prev_flag) && !cal_i;

    // Counts like a real counter: phase changes, cal edges and cal pulse length
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prev_a        <= 1'b1;
            prev_cal      <= 1'b0;
            prev_flag     <= 1'b0;
            width         <= 16'h0000;
            steps_o       <= 16'h0000;
            cal_edges_o   <= 16'h0000;
            cal_width_o   <= 16'h0000;
            flag_at_cal_o <= 1'b0;
            err_o         <= 16'h0000;
        end
        else
        begin
            prev_a    <= slow_a_i;
            prev_cal  <= cal_i;
            prev_flag <= flag_i;
            width     <= cal_i ? width + 16'h0001 : 16'h0000;
            if (slow_a_i != prev_a)
                steps_o <= steps_o + 16'h0001;
            if (cal_i && !prev_cal)
            begin
                cal_edges_o   <= cal_edges_o + 16'h0001;
                flag_at_cal_o <= flag_i;
            end
            if (!cal_i && prev_cal)
                cal_width_o <= width;
            err_o <= err_o + 16'(bad_phase) + 16'(bad_flag);
        end
    end
endmodule

// >>> rpp_datapath_tb_top.sv
// Self-checking bench for the real power pulse datapath
`timescale 1ns/1ps
module rpp_datapath_tb_top;
    logic        clk_i;
    logic        rst_i;
    logic [15:0] cur;
    logic [15:0] volt;
    logic        valid;
    logic        ready;
    logic        g_hi;
    logic        g_lo;
    logic        cal_sel;
    logic        slow_a;
    logic        slow_b;
    logic        cal;
    logic        flag;
    logic [15:0] steps;
    logic [15:0] edges;
    logic [15:0] width;
    logic        flag_cal;
    logic [15:0] perr;
    logic [15:0] cnt [4];
    logic [15:0] ecnt [2];
    int          bad_count;
    int          n_tests;
    int          taken;

    rpp_datapath dut_u (.clk_i(clk_i), .rst_i(rst_i), .cur_sample_i(cur),
        .volt_sample_i(volt), .sample_valid_i(valid), .sample_ready_o(ready),
        .gain_select_hi_i(g_hi), .gain_select_lo_i(g_lo), .calib_rate_select_i(cal_sel),
        .slow_pulse_out_a_o(slow_a), .slow_pulse_out_b_o(slow_b),
        .calib_pulse_out_o(cal), .negative_power_flag_o(flag));
    rpp_pulse_partner pm_u (.clk_i(clk_i), .rst_i(rst_i), .slow_a_i(slow_a),
        .slow_b_i(slow_b), .cal_i(cal), .flag_i(flag), .steps_o(steps),
        .cal_edges_o(edges), .cal_width_o(width), .flag_at_cal_o(flag_cal), .err_o(perr));

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Reset also clears the accumulators, so each run starts from zero energy
    task automatic do_reset();
        rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        #1;
        check("slow_a_rst", 16'(slow_a), 16'h0001);
        check("slow_b_rst", 16'(slow_b), 16'h0000);
        check("cal_rst", 16'(cal), 16'h0000);
        check("flag_rst", 16'(flag), 16'h0000);
        check("ready_rst", 16'(ready), 16'h0001);
        rst_i = 1'b0;
    endtask

    // Offer one pair and hold it until the buffer takes it
    task automatic send(input logic [15:0] c, input logic [15:0] v);
        int w;
        cur = c;
        volt = v;
        valid = 1'b1;
        w = 0;
        // Ready is registered, so its value between edges is what the next edge sees
        while (ready !== 1'b1 && w < 100)
        begin
            @(posedge clk_i);
            #1;
            w++;
        end
        @(posedge clk_i);
        #1;
        valid = 1'b0;
    endtask

    // Square waves at the 27-clock sample pace; the ac current survives dc removal
    task automatic stream(input int n, input logic [15:0] c, input logic [15:0] v);
        for (int i = 0; i < n; i++)
        begin
            send(i[0] ? -c : c, i[0] ? -v : v);
            repeat (26) @(posedge clk_i);
            #1;
        end
    endtask

    initial
    begin
        clk_i = 1'b0;
        cur = 16'h0000;
        volt = 16'h0000;
        valid = 1'b0;
        g_hi = 1'b0;
        g_lo = 1'b0;
        cal_sel = 1'b1;
        bad_count = 0;
        n_tests = 0;
        do_reset();
        // Back-to-back offers until the buffer refuses, then let it drain
        taken = 0;
        valid = 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            cur = i[15:0];
            taken += int'(ready);
            @(posedge clk_i);
            #1;
        end
        valid = 1'b0;
        check("fifo_taken", 16'(taken >= 8 && taken <= 9), 16'h0001);
        check("fifo_full", 16'(ready), 16'h0000);
        repeat (270) @(posedge clk_i);
        #1;
        check("fifo_drained", 16'(ready), 16'h0001);
        // Every gain code; higher gain means more energy and more steps
        for (int g = 0; g < 4; g++)
        begin
            {g_hi, g_lo} = g[1:0];
            do_reset();
            stream(300, 16'h0400, 16'h4000);
            cnt[g] = steps;
        end
        for (int g = 1; g < 4; g++)
            check("gain_order", 16'(cnt[g] >= cnt[g-1]), 16'h0001);
        check("gain_steps", 16'(cnt[3] > cnt[0]), 16'h0001);
        // Both calibration scalings at one small load
        {g_hi, g_lo} = 2'h0;
        for (int s = 0; s < 2; s++)
        begin
            cal_sel = s[0];
            do_reset();
            stream(400, 16'h0080, 16'h0100);
            ecnt[s] = edges;
        end
        check("cal_rate", 16'(ecnt[1] > ecnt[0]), 16'h0001);
        check("cal_fast", 16'(ecnt[1] >= 16'h0002), 16'h0001);
        check("cal_width", width, 16'h0101);
        // Reversed power raises the flag, forward power clears it again
        do_reset();
        stream(400, 16'h0080, 16'hff00);
        check("flag_neg", 16'(flag_cal), 16'h0001);
        stream(400, 16'h0080, 16'h0100);
        check("flag_pos", 16'(flag_cal), 16'h0000);
        check("partner_err", perr, 16'h0000);
        complete_run();
    end

    // About 76k cycles expected; cut a hang short well beyond that
    initial
    begin
        repeat (100000) @(posedge clk_i);
        bad_count++;
        $display("[FAIL] watchdog expected finish seen timeout");
        complete_run();
    end
endmodule
